// ==== bench/tb_top.sv ====
// Bench: encoder feeds decoder over one link, bench drains the FIFO
`timescale 1ns/100ps
module tb_top;
   import trc_pkg::*;
   logic sys_clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic req_n = 1'b1;
   logic req_drv = 1'b0;
   logic ack = 1'b1;
   trc_word_t pins = '0;
   trc_word_t local_addr = '0;
   logic [NUM_DIGITS-1:0] p_in;
   wire [NUM_DIGITS-1:0] p_out;
   wire [NUM_DIGITS-1:0] p_oe;
   logic [DATA_BITS-1:0] data, wdata, exp, old;
   logic busy, osc, vflag, wready, wvalid, vflag_ao;
   logic [DATA_BITS-1:0] notes [$];
   int failures = 0;
   int num_checks = 0;
   trc_link_if link ();
   always #25 sys_clk_in = ~sys_clk_in;
   // Open pins follow weak drive, else float to the opposite level
   always_comb begin
      for (int i = 0; i < NUM_DIGITS; i++) begin
         if (pins[i] == TRIT_OPEN) p_in[i] = p_oe[i] ? p_out[i] : ~p_out[i];
         else p_in[i] = pins[i][0];
      end
   end
   trc_encoder u_trc_encoder (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
      .link(link), .send_request_n_in(req_n), .send_request_drive_in(req_drv),
      .ext_clk_sel_in(1'b0), .osc_series_in(1'b0),
      .addr_digit_in(p_in[4:0]), .addr_digit_out(p_out[4:0]),
      .addr_digit_oe(p_oe[4:0]), .addr_data_in(p_in[8:5]),
      .addr_data_out(p_out[8:5]), .addr_data_oe(p_oe[8:5]),
      .osc_timing_capacitor_out(osc), .busy_out(busy));
   trc_decoder u_trc_decoder (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
      .link(link), .local_addr_in(local_addr), .data_out(data),
      .valid_word_flag_out(vflag), .word_ready_out(wready),
      .word_valid_out(wvalid), .word_ack_in(ack), .word_data_out(wdata));
   // Address-only build on the same line checks all nine digits
   trc_decoder #(.ADDR_ONLY(1'b1)) u_trc_decoder_ao (
      .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .link(link),
      .local_addr_in(local_addr), .data_out(),
      .valid_word_flag_out(vflag_ao), .word_ready_out(),
      .word_valid_out(), .word_ack_in(1'b1), .word_data_out());
   trc_link_sva u_trc_link_sva (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
      .serial(link.serial), .send_request_n_in(req_n),
      .send_request_drive_in(req_drv), .busy_out(busy),
      .osc_timing_capacitor_out(osc), .addr_digit_out(p_out[4:0]),
      .addr_digit_oe(p_oe[4:0]), .data_out(data), .valid_word_flag_out(vflag),
      .word_ready_out(wready), .word_valid_out(wvalid), .word_ack_in(ack));
   // ------
   // Tasks
   // ------
   task automatic check(input logic [3:0] seen, input logic [3:0] want);
      num_checks++;
      if (seen !== want) begin
         failures++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Sel 0 busy low, 1 FIFO full, 2 FIFO empty
   task automatic wait_until(input int sel, input int limit);
      int n;
      n = 0;
      while (!((sel == 0 && busy === 1'b0) || (sel == 1 && wready === 1'b0)
             || (sel == 2 && wvalid === 1'b0))) begin
         @(negedge sys_clk_in);
         n++;
         if (n > limit) begin
            check(4'(sel), 4'hf);
            print_verdict();
         end
      end
   endtask
   // Flip breaks the first local address digit
   task automatic new_word(input bit flip);
      trc_word_t w, a;
      for (int i = 0; i < NUM_DIGITS; i++) w[i] = 2'($urandom_range(2, 0));
      a = w;
      if (flip) a[0] = (w[0] == TRIT_LOW) ? TRIT_HIGH : TRIT_LOW;
      for (int i = 0; i < DATA_BITS; i++) exp[i] = (w[5 + i] != TRIT_LOW);
      @(posedge sys_clk_in);
      pins <= w;
      local_addr <= a;
   endtask
   task automatic send(input bit hold);
      @(posedge sys_clk_in);
      req_drv <= 1'b1;
      req_n <= 1'b0;
      @(posedge sys_clk_in);
      req_n <= ~hold;
      @(negedge sys_clk_in);
      check({3'h0, busy}, 4'h1);
   endtask
   // ------
   // Scoreboard and sequence
   // ------
   always @(posedge sys_clk_in) begin
      if (wvalid === 1'b1 && ack === 1'b1) begin
         if (notes.size() == 0) check(wdata, ~wdata);
         else check(wdata, notes.pop_front());
      end
   end
   initial begin
      void'($urandom(39));
      repeat (5) @(posedge sys_clk_in);
      nrst_in <= 1'b1;
      req_n <= 1'b0;
      repeat (20) @(negedge sys_clk_in);
      check({3'h0, busy}, 4'h0);
      new_word(1'b0);
      notes.push_back(exp); // One note per two words
      send(1'b0);
      wait_until(0, 5000);
      check(data, exp);
      check({3'h0, vflag}, 4'h1);
      check({3'h0, vflag_ao}, 4'h1);
      repeat (400) @(negedge sys_clk_in);
      check({3'h0, vflag}, 4'h0);
      old = exp;
      new_word(1'b1);
      send(1'b0);
      wait_until(0, 5000);
      check(data, old);
      check({3'h0, vflag}, 4'h0);
      check({3'h0, vflag_ao}, 4'h0);
      // Stall the FIFO while a held request keeps confirming words
      new_word(1'b0);
      ack <= 1'b0;
      repeat (FIFO_DEPTH) notes.push_back(exp);
      send(1'b1);
      wait_until(1, 80000);
      repeat (2500) @(negedge sys_clk_in);
      check({3'h0, wready}, 4'h0);
      @(posedge sys_clk_in);
      req_n <= 1'b1;
      wait_until(0, 5000);
      @(posedge sys_clk_in);
      ack <= 1'b1;
      wait_until(2, 100);
      check({3'h0, notes.size() == 0}, 4'h1);
      print_verdict();
   end
endmodule

// ==== bench/trc_link_sva.sv ====
// Concurrent checks on the codec link and both of its ends
`timescale 1ns/100ps
module trc_link_sva import trc_pkg::*; (
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   input wire logic serial,
   input wire logic send_request_n_in,
   input wire logic send_request_drive_in,
   input wire logic busy_out,
   input wire logic osc_timing_capacitor_out,
   input wire logic [ADDR_DIGITS-1:0] addr_digit_out,
   input wire logic [ADDR_DIGITS-1:0] addr_digit_oe,
   input wire logic [DATA_BITS-1:0] data_out,
   input wire logic valid_word_flag_out,
   input wire logic word_ready_out,
   input wire logic word_valid_out,
   input wire logic word_ack_in
);
   logic [9:0] hi_q;
   logic [9:0] lo_q;
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!nrst_in);
   // ------
   // Line level counters
   // ------
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) hi_q <= '0;
      else hi_q <= serial ? hi_q + 10'h1 : '0;
   end
   // Saturates, so a long silence never looks like a short low
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) lo_q <= 10'h3ff;
      else lo_q <= serial ? '0 : lo_q + {9'h0, lo_q != 10'h3ff};
   end
   // ------
   // Properties
   // ------
   sequence s_start;
      !busy_out && send_request_drive_in && !send_request_n_in;
   endsequence
   sequence s_sense;
      (&addr_digit_oe && &addr_digit_out) [*2]
      ##1 (&addr_digit_oe && ~|addr_digit_out) [*2] ##1 ~|addr_digit_oe;
   endsequence
   a_sense_walk: assert property (
      s_start |=> busy_out ##0 s_sense) else $error("sense walk wrong");
   a_pulse_width: assert property (
      $fell(serial) |-> hi_q == 10'h14 || hi_q == 10'h3c)
      else $error("pulse high time wrong");
   a_low_width: assert property (
      $rose(serial) |-> lo_q == 10'h14 || lo_q == 10'h3c || lo_q >= 10'h1f4)
      else $error("pulse low time wrong");
   a_valid_silence: assert property (
      lo_q >= 10'h2a3 |-> !valid_word_flag_out)
      else $error("valid kept after silence");
   a_valid_recent: assert property (
      $rose(valid_word_flag_out) |-> lo_q < 10'h40)
      else $error("valid rose without a word");
   a_data_hold: assert property (
      !$stable(data_out) |-> valid_word_flag_out)
      else $error("data changed without valid");
   a_idle_quiet: assert property (
      !busy_out ##1 !busy_out |-> !osc_timing_capacitor_out && !serial)
      else $error("idle encoder not quiet");
   a_undriven_idle: assert property (
      !busy_out && !send_request_drive_in |=> !busy_out)
      else $error("undriven request started");
   a_full_has_data: assert property (
      !word_ready_out |-> word_valid_out)
      else $error("full fifo empty");
   a_pop_frees: assert property (
      !word_ready_out && word_valid_out && word_ack_in |=> word_ready_out)
      else $error("pop at full kept full");
endmodule

// ==== hdl/trc_decoder.sv ====
// Codec decoder: pulse classifier, double-word check, word FIFO
//
// Functional notes
// RQ1 - Encoder pins read low, high or open
// RQ2 - Low request sends; held low repeats
// RQ3 - Never trust a lone first word
// RQ4 - Three quiet data periods between words
// RQ5 - Digit as two short/long pulses
// RQ6 - Weak high then low classifies pins
// RQ7 - Idle and oscillator off after sequence
// RQ8 - Request starts oscillator, sensing, shifting
// RQ9 - Five address digits; match stores nibble
// RQ10 - Second match and equal nibble validate
// RQ11 - Data outputs hold until next valid
// RQ12 - Valid drops on mismatch or silence
// RQ13 - Open data digit decodes as one
// RQ14 - Address-only variant compares nine digits
// RQ15 - Local address must equal encoder pins
// RQ16 - Width threshold 1.72 encoder periods
// RQ17 - End of transmission after 33.5 periods
// RQ18 - Word gap at 0.4 of that
// RQ19 - External clock enters series input
// RQ20 - Request pin pulled up, inactive high
// RQ21 - Sample line at threshold after rise
`timescale 1ns/100ps
module trc_decoder #(
   parameter bit ADDR_ONLY = 1'b0,
   parameter int FIFO_DEPTH = trc_pkg::FIFO_DEPTH
) (
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   trc_link_if.dec link,
   input wire trc_pkg::trc_word_t local_addr_in,
   output logic [trc_pkg::DATA_BITS-1:0] data_out,
   output logic valid_word_flag_out,
   output logic word_ready_out,
   output logic word_valid_out,
   input wire logic word_ack_in,
   output logic [trc_pkg::DATA_BITS-1:0] word_data_out
);
   import trc_pkg::*;

   localparam int CW = $clog2(EOT_CYC + 1);
   localparam logic [CW-1:0] THR_C = CW'(PW_THR_CYC);
   localparam logic [CW-1:0] GAP_C = CW'(GAP_CYC - 1);
   localparam logic [CW-1:0] EOT_C = CW'(EOT_CYC - 1);
   localparam logic [CW-1:0] SAT_C = CW'(EOT_CYC);
   localparam logic [3:0] DIG_FULL = 4'(NUM_DIGITS);
   localparam logic [3:0] DIG_LAST = 4'(NUM_DIGITS - 1);

   logic din_q;
   logic rise;
   logic [CW-1:0] hi_cnt_q;
   logic [CW-1:0] lo_cnt_q;
   logic sample_stb;
   logic gap_stb;
   logic eot_stb;
   logic half_q;
   logic first_long_q;
   logic [3:0] dig_q;
   trc_word_t rx_q;
   logic bad_q;
   logic err_stb;
   logic [1:0] trit_c;
   logic pair_bad;
   logic word_done_q;
   logic [NUM_DIGITS-1:0] eq;
   logic match;
   logic [DATA_BITS-1:0] nib_c;
   logic [DATA_BITS-1:0] nib_q;
   logic [DATA_BITS-1:0] data_q;
   logic have_first_q;
   logic valid_q;
   logic confirm;
   logic push;

   // ---------------------------------------------------------------
   // Pulse width timer
   // ---------------------------------------------------------------
   assign rise = link.serial & ~din_q;
   // One decision per pulse, at the threshold after the rising edge
   assign sample_stb = hi_cnt_q == THR_C; // [RQ16] [RQ21]

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         din_q <= 1'b0;
         hi_cnt_q <= '0;
      end else begin
         din_q <= link.serial;
         if (rise) begin
            hi_cnt_q <= CW'(1);
         end else if (sample_stb || hi_cnt_q == '0) begin
            hi_cnt_q <= '0;
         end else begin
            hi_cnt_q <= hi_cnt_q + 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Word gap timer
   // ---------------------------------------------------------------
   // Low-time counter saturates so each threshold fires once per gap
   assign gap_stb = ~link.serial && lo_cnt_q == GAP_C; // [RQ18]
   assign eot_stb = ~link.serial && lo_cnt_q == EOT_C; // [RQ17]

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         lo_cnt_q <= '0;
      end else if (link.serial) begin
         lo_cnt_q <= '0;
      end else if (lo_cnt_q != SAT_C) begin
         lo_cnt_q <= lo_cnt_q + 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Digit assembly
   // ---------------------------------------------------------------
   // Short-short low, long-long high, long-short open; short-long is illegal
   always_comb begin
      trit_c = TRIT_LOW;
      pair_bad = 1'b0;
      unique case ({first_long_q, link.serial})
         2'b00: trit_c = TRIT_LOW; // [RQ5]
         2'b11: trit_c = TRIT_HIGH; // [RQ5]
         2'b10: trit_c = TRIT_OPEN; // [RQ5]
         2'b01: pair_bad = 1'b1;
      endcase
   end

   // A stray pulse past the ninth digit spoils the word too
   assign err_stb = sample_stb && !bad_q &&
                    (dig_q == DIG_FULL || (half_q && pair_bad));

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         half_q <= 1'b0;
         first_long_q <= 1'b0;
         dig_q <= '0;
         bad_q <= 1'b0;
         word_done_q <= 1'b0;
      end else begin
         word_done_q <= 1'b0;
         if (gap_stb) begin
            // Partial words are thrown away at the gap
            half_q <= 1'b0;
            dig_q <= '0;
            bad_q <= 1'b0;
         end else if (err_stb) begin
            bad_q <= 1'b1;
         end else if (sample_stb && !bad_q) begin
            if (!half_q) begin
               first_long_q <= link.serial; // [RQ21]
               half_q <= 1'b1;
            end else begin
               half_q <= 1'b0;
               dig_q <= dig_q + 1'b1;
               word_done_q <= dig_q == DIG_LAST;
            end
         end
      end
   end

   generate
      for (genvar i = 0; i < NUM_DIGITS; i++) begin : g_rx
         always_ff @(posedge sys_clk_in or negedge nrst_in) begin
            if (!nrst_in) begin
               rx_q[i] <= TRIT_LOW;
            end else if (sample_stb && !bad_q && half_q && !pair_bad &&
                         dig_q == 4'(i)) begin
               rx_q[i] <= trit_c;
            end
         end
         // Trits compared exactly; data digits skipped unless
         // the address-only variant is built [RQ9] [RQ14] [RQ15]
         assign eq[i] = (rx_q[i] == local_addr_in[i]) ||
                        (!ADDR_ONLY && i >= ADDR_DIGITS);
      end
      for (genvar j = 0; j < DATA_BITS; j++) begin : g_nib
         // Only low reads as zero; open counts as one [RQ13]
         assign nib_c[j] = rx_q[ADDR_DIGITS + j] != TRIT_LOW;
      end
   endgenerate

   assign match = &eq;

   // ---------------------------------------------------------------
   // Double-word check
   // ---------------------------------------------------------------
   // A lone first word never validates, power-up garbage included
   assign confirm = word_done_q && match && have_first_q &&
                    (ADDR_ONLY || nib_c == nib_q); // [RQ3] [RQ10] [RQ14]

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         valid_q <= 1'b0;
         have_first_q <= 1'b0;
         nib_q <= '0;
      end else if (eot_stb || err_stb) begin
         valid_q <= 1'b0; // [RQ12]
         have_first_q <= 1'b0;
      end else if (word_done_q) begin
         if (!match) begin
            valid_q <= 1'b0; // [RQ12]
            have_first_q <= 1'b0;
         end else begin
            // Stored without touching the outputs [RQ9]
            nib_q <= nib_c;
            have_first_q <= 1'b1;
            valid_q <= confirm; // [RQ10] [RQ12]
         end
      end
   end

   // Data outputs change only on a confirmed word [RQ10] [RQ11]
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         data_q <= '0;
      end else if (confirm && !ADDR_ONLY) begin
         data_q <= nib_c;
      end
   end

   assign data_out = data_q;
   assign valid_word_flag_out = valid_q;

   // ---------------------------------------------------------------
   // Confirmed word queue
   // ---------------------------------------------------------------
   // The link cannot be stalled, so a word confirmed while the
   // queue is full is not queued; word_ready_out shows that
   assign push = confirm;

   trc_fifo #(
      .W(DATA_BITS),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .sys_clk_in(sys_clk_in),
      .nrst_in(nrst_in),
      .in_valid_in(push),
      .in_ready_out(word_ready_out),
      .in_data_in(ADDR_ONLY ? '0 : nib_c),
      .out_valid_out(word_valid_out),
      .out_ready_in(word_ack_in),
      .out_data_out(word_data_out)
   );
endmodule

// ==== hdl/trc_encoder.sv ====
// Codec encoder: senses nine trinary pins and sends double words
`timescale 1ns/100ps
module trc_encoder (
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   trc_link_if.enc link,
   input wire logic send_request_n_in,
   input wire logic send_request_drive_in,
   input wire logic ext_clk_sel_in,
   input wire logic osc_series_in,
   input wire logic [trc_pkg::ADDR_DIGITS-1:0] addr_digit_in,
   output logic [trc_pkg::ADDR_DIGITS-1:0] addr_digit_out,
   output logic [trc_pkg::ADDR_DIGITS-1:0] addr_digit_oe,
   input wire logic [trc_pkg::DATA_BITS-1:0] addr_data_in,
   output logic [trc_pkg::DATA_BITS-1:0] addr_data_out,
   output logic [trc_pkg::DATA_BITS-1:0] addr_data_oe,
   output logic osc_timing_capacitor_out,
   output logic busy_out
);
   import trc_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE, ST_SENSE_HI, ST_SENSE_LO, ST_SEND, ST_GAP
   } trc_enc_state_e;

   localparam int DW = $clog2(ENC_DIV);
   localparam logic [DW-1:0] DIV_LAST = DW'(ENC_DIV - 1);
   localparam logic [DW-1:0] DIV_HALF = DW'(ENC_HALF);
   localparam logic [1:0] SUB_LAST = 2'(TICKS_PER_PULSE - 1);
   localparam logic [1:0] SUB_LONG = 2'(LONG_HIGH_TICKS);
   localparam logic [4:0] PULSE_LAST = 5'(PULSES_PER_WORD - 1);
   localparam logic [4:0] GAP_LAST = 5'(GAP_TICKS - 1);
   localparam logic [1:0] SENSE_LAST = 2'(SENSE_CYC - 1);

   trc_enc_state_e state_q;
   logic [DW-1:0] div_q;
   logic ext_q;
   logic osc_q;
   logic tick;
   logic run;
   logic req_act;
   logic [1:0] sense_q;
   logic [NUM_DIGITS-1:0] pins;
   logic [NUM_DIGITS-1:0] hi_rd_q;
   trc_word_t word_q;
   logic [1:0] sub_q;
   logic [4:0] pulse_q;
   logic [4:0] gap_q;
   logic second_q;
   logic ser_q;
   logic [1:0] cur_trit;
   logic long_pulse;

   // ---------------------------------------------------------------
   // Request and oscillator
   // ---------------------------------------------------------------
   // Undriven request rests high, as with a pull-up [RQ20]
   assign req_act = send_request_drive_in & ~send_request_n_in; // [RQ2]
   assign run = state_q != ST_IDLE;
   assign pins = {addr_data_in, addr_digit_in};

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         div_q <= '0;
         osc_q <= 1'b0;
         ext_q <= 1'b0;
      end else begin
         ext_q <= osc_series_in;
         // Divider frozen while idle or clocked externally [RQ7] [RQ19]
         // Restarts per double word so its first pulse is full width [RQ5]
         if (ext_clk_sel_in ||
             !(state_q == ST_SEND || state_q == ST_GAP)) begin
            div_q <= '0;
         end else begin
            div_q <= (div_q == DIV_LAST) ? '0 : div_q + 1'b1;
         end
         osc_q <= run & ~ext_clk_sel_in & (div_q < DIV_HALF);
      end
   end

   // External source replaces the oscillator on its rising edge [RQ19]
   assign tick = ext_clk_sel_in ? (osc_series_in & ~ext_q)
                                : (run && div_q == DIV_LAST);

   // ---------------------------------------------------------------
   // Pin sensing
   // ---------------------------------------------------------------
   // Weak drive high, then low; a hardwired pin overrides it [RQ6]
   assign addr_digit_oe = {ADDR_DIGITS{state_q == ST_SENSE_HI ||
                                       state_q == ST_SENSE_LO}};
   assign addr_data_oe = {DATA_BITS{state_q == ST_SENSE_HI ||
                                    state_q == ST_SENSE_LO}};
   assign addr_digit_out = {ADDR_DIGITS{state_q == ST_SENSE_HI}};
   assign addr_data_out = {DATA_BITS{state_q == ST_SENSE_HI}};

   generate
      for (genvar i = 0; i < NUM_DIGITS; i++) begin : g_sense
         always_ff @(posedge sys_clk_in or negedge nrst_in) begin
            if (!nrst_in) begin
               hi_rd_q[i] <= 1'b0;
               word_q[i] <= TRIT_LOW;
            end else if (sense_q == SENSE_LAST) begin
               if (state_q == ST_SENSE_HI) begin
                  hi_rd_q[i] <= pins[i];
               end else if (state_q == ST_SENSE_LO) begin
                  // Three levels per pin give the full code space [RQ1]
                  if (hi_rd_q[i] && pins[i]) begin
                     word_q[i] <= TRIT_HIGH; // [RQ6]
                  end else if (!hi_rd_q[i] && !pins[i]) begin
                     word_q[i] <= TRIT_LOW; // [RQ6]
                  end else begin
                     word_q[i] <= TRIT_OPEN; // [RQ6]
                  end
               end
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_q <= ST_IDLE;
         sense_q <= '0;
         sub_q <= '0;
         pulse_q <= '0;
         gap_q <= '0;
         second_q <= 1'b0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (req_act) begin
                  state_q <= ST_SENSE_HI; // [RQ8]
               end
            end
            ST_SENSE_HI, ST_SENSE_LO: begin
               sense_q <= sense_q + 1'b1;
               if (sense_q == SENSE_LAST) begin
                  sense_q <= '0;
                  state_q <= (state_q == ST_SENSE_HI) ? ST_SENSE_LO
                                                      : ST_SEND; // [RQ8]
               end
            end
            ST_SEND: begin
               if (tick) begin
                  sub_q <= sub_q + 1'b1;
                  if (sub_q == SUB_LAST) begin
                     pulse_q <= pulse_q + 1'b1;
                     if (pulse_q == PULSE_LAST) begin
                        pulse_q <= '0;
                        gap_q <= '0;
                        state_q <= ST_GAP;
                     end
                  end
               end
            end
            ST_GAP: begin
               if (tick) begin
                  gap_q <= gap_q + 1'b1;
                  // Line stays quiet for three data periods [RQ4]
                  if (gap_q == GAP_LAST) begin
                     second_q <= ~second_q;
                     if (!second_q) begin
                        state_q <= ST_SEND; // [RQ2]
                     end else if (req_act) begin
                        state_q <= ST_SENSE_HI; // [RQ2]
                     end else begin
                        state_q <= ST_IDLE; // [RQ7]
                     end
                  end
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Pulse shaping
   // ---------------------------------------------------------------
   assign cur_trit = word_q[pulse_q[4:1]];
   // Open sends long then short; high two longs; low two shorts [RQ5]
   assign long_pulse = (cur_trit == TRIT_HIGH) ||
                       (cur_trit == TRIT_OPEN && !pulse_q[0]);

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ser_q <= 1'b0;
      end else begin
         ser_q <= (state_q == ST_SEND) &&
                  (sub_q == '0 || (long_pulse && sub_q < SUB_LONG)); // [RQ5]
      end
   end

   assign link.serial = ser_q;
   assign osc_timing_capacitor_out = osc_q;
   assign busy_out = run;
endmodule

// ==== hdl/trc_fifo.sv ====
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
module trc_fifo #(
   parameter int W = 4,
   parameter int DEPTH = 32
) (
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [W-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [W-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready_out = cnt_q != FULL_CNT;
   assign out_valid_out = cnt_q != '0;
   assign push = in_valid_in & in_ready_out;
   assign pop = out_valid_out & out_ready_in;
   assign out_data_out = mem_q[rd_q];

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
      end else if (push) begin
         mem_q[wr_q] <= in_data_in;
      end
   end

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule

// ==== shared/trc_link_if.sv ====
// Serial link between codec encoder and decoder
`timescale 1ns/100ps
interface trc_link_if;
   logic serial;
   modport enc (output serial);
   modport dec (input serial);
endinterface

// ==== shared/trc_pkg.sv ====
// Shared constants and types for the trinary remote codec pair
package trc_pkg;

   // ---------------------------------------------------------------
   // Clocking
   // ---------------------------------------------------------------
   localparam int SYS_CLK_NS = 50;
   localparam int ENC_CLK_NS = 1000;
   localparam int ENC_DIV = ENC_CLK_NS / SYS_CLK_NS;
   localparam int ENC_HALF = ENC_DIV / 2;

   // ---------------------------------------------------------------
   // Word layout
   // ---------------------------------------------------------------
   localparam int NUM_DIGITS = 9;
   localparam int ADDR_DIGITS = 5;
   localparam int DATA_BITS = 4;
   localparam int CODE_SPACE = 19683;
   localparam logic [1:0] TRIT_LOW = 2'h0;
   localparam logic [1:0] TRIT_HIGH = 2'h1;
   localparam logic [1:0] TRIT_OPEN = 2'h2;
   typedef logic [NUM_DIGITS-1:0][1:0] trc_word_t;

   // ---------------------------------------------------------------
   // Encoder timing, in encoder clock ticks; sensing in system cycles
   // ---------------------------------------------------------------
   localparam int TICKS_PER_PULSE = 4;
   localparam int LONG_HIGH_TICKS = 3;
   localparam int PULSES_PER_WORD = 2 * NUM_DIGITS;
   localparam int DATA_PERIOD_TICKS = 2 * TICKS_PER_PULSE;
   localparam int WORD_GAP_PERIODS = 3;
   localparam int GAP_TICKS = WORD_GAP_PERIODS * DATA_PERIOD_TICKS;
   localparam int SENSE_CYC = 2;

   // ---------------------------------------------------------------
   // Decoder timing, in encoder periods then system cycles
   // ---------------------------------------------------------------
   localparam int PW_THR_X100 = 172;
   localparam int EOT_X10 = 335;
   localparam int GAP_FRAC_X10 = 4;
   localparam int PW_THR_CYC =
      (PW_THR_X100 * ENC_CLK_NS) / (100 * SYS_CLK_NS);
   localparam int EOT_CYC = (EOT_X10 * ENC_CLK_NS) / (10 * SYS_CLK_NS);
   localparam int GAP_CYC = (EOT_CYC * GAP_FRAC_X10) / 10;

   // ---------------------------------------------------------------
   // Buffering
   // ---------------------------------------------------------------
   localparam int FIFO_DEPTH = 32;

endpackage
